// [sgx_core.sv]
// Behaviour
// - Alert pin pulls low while any unmasked input differs from its input register.
// - All per-line interrupt masks are set after reset.
// - Reset loads every register default and returns the bus machine to idle.
// - Three strap inputs form the low three bits of the slave address.
// - After reset every line is an input with its pull-up enabled.
// - Sixteen lines with input, output, polarity and direction byte pairs.
// - Each bank selects push-pull or open-drain output drive.
// - A read-only source register shows which lines cause the alert.
// - Each output line holds a two-bit drive strength setting.
// - A latched line keeps its captured change until its input port is read.
// - Each line has a pull resistor enable bit.
// - Each line has a pull-up or pull-down select bit.
// - A set mask bit keeps that line from raising the alert.
// - Address byte bit zero set means read, clear means write.
// - The byte after the address is stored as the register pointer.
// - Pointers 00h to 07h select input, output, polarity, direction pairs.
`timescale 1ns/1ps
module sgx_core
#(
    parameter logic [3:0] ADDR_PREFIX = sgx_pkg::ADDR_PREFIX_DEF
)
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic SLAVE_ADDR_STRAP_LSB,
    input wire logic SLAVE_ADDR_STRAP_MID,
    input wire logic SLAVE_ADDR_STRAP_MSB,
    input wire logic [sgx_pkg::NUM_LINES-1:0] GPIO_I,
    output logic [sgx_pkg::NUM_LINES-1:0] GPIO_O,
    output logic [sgx_pkg::NUM_LINES-1:0] GPIO_OE,
    output logic [2*sgx_pkg::NUM_LINES-1:0] GPIO_DRIVE,
    output logic [sgx_pkg::NUM_LINES-1:0] GPIO_PULL_EN,
    output logic [sgx_pkg::NUM_LINES-1:0] GPIO_PULL_UP,
    output logic ALERT_N_O,
    output logic ALERT_N_OE
);
    import sgx_pkg::*;

    // Pins are asynchronous to MCLK; the first stage is read only by the second.
    logic [1:0] scl_s1, scl_s2, sda_s1, sda_s2;
    logic [2:0] strap_s1, strap_s2;
    logic [15:0] gpio_s1, gpio_s2;
    logic scl_d, sda_d;

    always_ff @(posedge MCLK)
    begin
        scl_s1 <= {scl_s1[0], SCL_I};
        sda_s1 <= {sda_s1[0], SDA_I};
        strap_s1 <= {SLAVE_ADDR_STRAP_MSB, SLAVE_ADDR_STRAP_MID, SLAVE_ADDR_STRAP_LSB};
        gpio_s1 <= GPIO_I;
        scl_s2 <= {scl_s2[0], scl_s1[1]};
        sda_s2 <= {sda_s2[0], sda_s1[1]};
        strap_s2 <= strap_s1;
        gpio_s2 <= gpio_s1;
    end

    assign scl_d = scl_s2[1];
    assign sda_d = sda_s2[1];

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2[1] & ~scl_s2[0] ? 1'b0 : (~scl_s2[1] & scl_s2[0]);
    assign scl_fall = scl_s2[1] & ~scl_s2[0];
    assign bus_start = scl_d & scl_s2[0] & sda_s2[1] & ~sda_s2[0];
    assign bus_stop = scl_d & scl_s2[0] & ~sda_s2[1] & sda_s2[0];

    sgx_state_t state_reg, state_next;
    sgx_cfg_t cfg_reg, cfg_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next;
    logic rw_reg, rw_next, oe_reg, oe_next, alert_reg, alert_next;
    logic [15:0] in_reg, in_next, lat_pend_reg, lat_pend_next, lat_val_reg, lat_val_next;
    logic [15:0] cur, rep, int_src, rd_clr;
    logic [6:0] my_addr;

    assign my_addr = {ADDR_PREFIX, strap_s2};
    assign cur = gpio_s2 ^ cfg_reg.pol;
    // A latched line reports its captured value until its port is read.
    assign rep = (lat_pend_reg & lat_val_reg) | (~lat_pend_reg & cur);
    assign int_src = (rep ^ in_reg) & ~cfg_reg.mask;

    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [15:0] r,
                                           input sgx_cfg_t c, input logic [15:0] s);
        logic [7:0] v;
        v = 8'h00;
        case (p)
            PTR_IN0: v = r[7:0];
            PTR_IN1: v = r[15:8];
            PTR_OUT0: v = c.out[7:0];
            PTR_OUT1: v = c.out[15:8];
            PTR_POL0: v = c.pol[7:0];
            PTR_POL1: v = c.pol[15:8];
            PTR_DIR0: v = c.dir[7:0];
            PTR_DIR1: v = c.dir[15:8];
            PTR_DRV0: v = c.drv[7:0];
            PTR_DRV1: v = c.drv[15:8];
            PTR_DRV2: v = c.drv[23:16];
            PTR_DRV3: v = c.drv[31:24];
            PTR_LAT0: v = c.latch[7:0];
            PTR_LAT1: v = c.latch[15:8];
            PTR_PEN0: v = c.pull_en[7:0];
            PTR_PEN1: v = c.pull_en[15:8];
            PTR_PSEL0: v = c.pull_up[7:0];
            PTR_PSEL1: v = c.pull_up[15:8];
            PTR_MASK0: v = c.mask[7:0];
            PTR_MASK1: v = c.mask[15:8];
            PTR_SRC0: v = s[7:0];
            PTR_SRC1: v = s[15:8];
            PTR_OCFG: v = {6'h00, c.open_drain};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb
    begin
        logic [7:0] p;
        p = 8'h00;
        state_next = state_reg;
        cfg_next = cfg_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        rd_clr = 16'h0000;
        if (bus_stop)
        begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end
        else if (bus_start)
        begin
            state_next = ST_ADDR;
            cnt_next = CNT_ZERO;
            oe_next = 1'b0;
        end
        else if (scl_rise && (state_reg == ST_ADDR || state_reg == ST_CMD
                 || state_reg == ST_WR) && cnt_reg != BYTE_BITS)
        begin
            sh_next = {sh_reg[6:0], sda_d};
            cnt_next = cnt_reg + CNT_ONE;
        end
        else if (scl_rise && state_reg == ST_RD_ACK && sda_d)
        begin
            state_next = ST_IDLE; // Master NACK ends the read.
        end
        else if (scl_fall)
        begin
            case (state_reg)
                ST_ADDR:
                    if (cnt_reg == BYTE_BITS)
                    begin
                        if (sh_reg[7:1] == my_addr)
                        begin
                            state_next = ST_ADDR_ACK;
                            rw_next = sh_reg[0];
                            oe_next = 1'b1;
                        end
                        else
                            state_next = ST_IDLE;
                    end
                ST_ADDR_ACK:
                    if (rw_reg)
                    begin
                        p = ptr_reg;
                        tx_next = rd_byte(p, rep, cfg_reg, int_src);
                        oe_next = ~tx_next[7];
                        cnt_next = CNT_ONE;
                        state_next = ST_RD;
                    end
                    else
                    begin
                        oe_next = 1'b0;
                        cnt_next = CNT_ZERO;
                        state_next = ST_CMD;
                    end
                ST_CMD:
                    if (cnt_reg == BYTE_BITS)
                    begin
                        ptr_next = sh_reg;
                        oe_next = 1'b1;
                        state_next = ST_CMD_ACK;
                    end
                ST_CMD_ACK, ST_WR_ACK:
                begin
                    if (state_reg == ST_WR_ACK)
                        ptr_next = {ptr_reg[7:1], ~ptr_reg[0]};
                    oe_next = 1'b0;
                    cnt_next = CNT_ZERO;
                    state_next = ST_WR;
                end
                ST_WR:
                    if (cnt_reg == BYTE_BITS)
                    begin
                        oe_next = 1'b1;
                        state_next = ST_WR_ACK;
                        case (ptr_reg)
                            PTR_OUT0: cfg_next.out[7:0] = sh_reg;
                            PTR_OUT1: cfg_next.out[15:8] = sh_reg;
                            PTR_POL0: cfg_next.pol[7:0] = sh_reg;
                            PTR_POL1: cfg_next.pol[15:8] = sh_reg;
                            PTR_DIR0: cfg_next.dir[7:0] = sh_reg;
                            PTR_DIR1: cfg_next.dir[15:8] = sh_reg;
                            PTR_DRV0: cfg_next.drv[7:0] = sh_reg;
                            PTR_DRV1: cfg_next.drv[15:8] = sh_reg;
                            PTR_DRV2: cfg_next.drv[23:16] = sh_reg;
                            PTR_DRV3: cfg_next.drv[31:24] = sh_reg;
                            PTR_LAT0: cfg_next.latch[7:0] = sh_reg;
                            PTR_LAT1: cfg_next.latch[15:8] = sh_reg;
                            PTR_PEN0: cfg_next.pull_en[7:0] = sh_reg;
                            PTR_PEN1: cfg_next.pull_en[15:8] = sh_reg;
                            PTR_PSEL0: cfg_next.pull_up[7:0] = sh_reg;
                            PTR_PSEL1: cfg_next.pull_up[15:8] = sh_reg;
                            PTR_MASK0: cfg_next.mask[7:0] = sh_reg;
                            PTR_MASK1: cfg_next.mask[15:8] = sh_reg;
                            PTR_OCFG: cfg_next.open_drain = sh_reg[1:0];
                            default: cfg_next = cfg_reg;
                        endcase
                    end
                ST_RD:
                    if (cnt_reg == BYTE_BITS)
                    begin
                        oe_next = 1'b0;
                        state_next = ST_RD_ACK;
                    end
                    else
                    begin
                        oe_next = ~tx_reg[6];
                        tx_next = {tx_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + CNT_ONE;
                    end
                ST_RD_ACK:
                begin
                    p = {ptr_reg[7:1], ~ptr_reg[0]};
                    ptr_next = p;
                    tx_next = rd_byte(p, rep, cfg_reg, int_src);
                    oe_next = ~tx_next[7];
                    cnt_next = CNT_ONE;
                    state_next = ST_RD;
                end
                default: state_next = ST_IDLE;
            endcase
        end
        // Loading an input port byte counts as reading that port.
        if (state_next == ST_RD && state_reg != ST_RD && p[7:1] == PTR_IN0[7:1])
            rd_clr = p[0] ? 16'hFF00 : 16'h00FF;
    end

    always_comb
    begin
        // A new latched change in the same cycle as a read survives the clear.
        in_next = (in_reg & ~rd_clr) | (rep & rd_clr);
        lat_pend_next = (lat_pend_reg & ~rd_clr)
                      | (cfg_reg.latch & ~lat_pend_reg & (cur ^ in_reg));
        lat_val_next = (lat_pend_reg & lat_val_reg) | (~lat_pend_reg & cur);
        alert_next = |int_src;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= ST_IDLE;
            cfg_reg <= CFG_RST;
            cnt_reg <= CNT_ZERO;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= PTR_IN0;
            rw_reg <= 1'b0;
            oe_reg <= 1'b0;
            in_reg <= 16'h0000;
            lat_pend_reg <= 16'h0000;
            lat_val_reg <= 16'h0000;
            alert_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            in_reg <= in_next;
            lat_pend_reg <= lat_pend_next;
            lat_val_reg <= lat_val_next;
            alert_reg <= alert_next;
        end
    end

    // Open-drain banks only sink; a high output is left to the external pull.
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++)
        begin : g_line
            assign GPIO_OE[g] = ~cfg_reg.dir[g]
                & (~cfg_reg.open_drain[g / PORT_W] | ~cfg_reg.out[g]);
        end
    endgenerate

    assign GPIO_O = cfg_reg.out;
    assign GPIO_DRIVE = cfg_reg.drv;
    assign GPIO_PULL_EN = cfg_reg.pull_en;
    assign GPIO_PULL_UP = cfg_reg.pull_up;
    assign SDA_O = 1'b0;
    assign SDA_OE = oe_reg;
    assign ALERT_N_O = 1'b0;
    assign ALERT_N_OE = alert_reg;

    chk_alert_follow: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (|int_src) |=> ALERT_N_OE)
        else $error("alert not raised for unmasked change");
    chk_mask_reset: assert property (@(posedge MCLK)
        $fell(SYS_RST) |-> (cfg_reg.mask == CFG_RST.mask && !ALERT_N_OE))
        else $error("masks not set after reset");
    chk_reset_idle: assert property (@(posedge MCLK)
        $fell(SYS_RST) |-> (state_reg == ST_IDLE && ptr_reg == PTR_IN0 && !SDA_OE))
        else $error("bus machine not idle after reset");
    chk_addr_match: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (state_reg == ST_ADDR && state_next == ST_ADDR_ACK) |-> sh_reg[7:1] == my_addr)
        else $error("acknowledged a foreign address");
    chk_pull_reset: assert property (@(posedge MCLK)
        $fell(SYS_RST) |-> (GPIO_OE == 16'h0000 && GPIO_PULL_EN == 16'hFFFF
                            && GPIO_PULL_UP == 16'hFFFF))
        else $error("lines not inputs with pull-ups after reset");
    chk_open_drain: assert property (@(posedge MCLK) disable iff (SYS_RST)
        cfg_reg.open_drain[0] |-> (GPIO_OE[7:0] & cfg_reg.out[7:0]) == 8'h00)
        else $error("open-drain bank drives high");
    chk_mask_gate: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (int_src & cfg_reg.mask) == 16'h0000)
        else $error("masked line reaches source");
    chk_latch_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (lat_pend_reg[0] && rd_clr[0] == 1'b0) |=> (lat_pend_reg[0]
            && lat_val_reg[0] == $past(lat_val_reg[0])))
        else $error("latched change lost before read");
    chk_ptr_store: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (state_reg == ST_CMD && state_next == ST_CMD_ACK) |=> ptr_reg == $past(sh_reg))
        else $error("pointer not taken from command byte");
    chk_polarity: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !lat_pend_reg[3] |-> rep[3] == (gpio_s2[3] ^ cfg_reg.pol[3]))
        else $error("polarity inversion wrong");
endmodule

// [sgx_pkg.sv]
package sgx_pkg;

    localparam int NUM_LINES = 16;
    localparam int PORT_W = 8;

    // Pointer codes: base pairs, then the extended pairs and the single output configuration byte.
    localparam logic [7:0] PTR_IN0 = 8'h00;
    localparam logic [7:0] PTR_IN1 = 8'h01;
    localparam logic [7:0] PTR_OUT0 = 8'h02;
    localparam logic [7:0] PTR_OUT1 = 8'h03;
    localparam logic [7:0] PTR_POL0 = 8'h04;
    localparam logic [7:0] PTR_POL1 = 8'h05;
    localparam logic [7:0] PTR_DIR0 = 8'h06;
    localparam logic [7:0] PTR_DIR1 = 8'h07;
    localparam logic [7:0] PTR_DRV0 = 8'h40;
    localparam logic [7:0] PTR_DRV1 = 8'h41;
    localparam logic [7:0] PTR_DRV2 = 8'h42;
    localparam logic [7:0] PTR_DRV3 = 8'h43;
    localparam logic [7:0] PTR_LAT0 = 8'h44;
    localparam logic [7:0] PTR_LAT1 = 8'h45;
    localparam logic [7:0] PTR_PEN0 = 8'h46;
    localparam logic [7:0] PTR_PEN1 = 8'h47;
    localparam logic [7:0] PTR_PSEL0 = 8'h48;
    localparam logic [7:0] PTR_PSEL1 = 8'h49;
    localparam logic [7:0] PTR_MASK0 = 8'h4A;
    localparam logic [7:0] PTR_MASK1 = 8'h4B;
    localparam logic [7:0] PTR_SRC0 = 8'h4C;
    localparam logic [7:0] PTR_SRC1 = 8'h4D;
    localparam logic [7:0] PTR_OCFG = 8'h4F;

    localparam logic [3:0] ADDR_PREFIX_DEF = 4'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] pol;
        logic [15:0] dir;
        logic [31:0] drv;
        logic [15:0] latch;
        logic [15:0] pull_en;
        logic [15:0] pull_up;
        logic [15:0] mask;
        logic [1:0] open_drain;
    } sgx_cfg_t;

    localparam sgx_cfg_t CFG_RST = '{
        out: 16'hFFFF,
        pol: 16'h0000,
        dir: 16'hFFFF,
        drv: 32'hFFFFFFFF,
        latch: 16'h0000,
        pull_en: 16'hFFFF,
        pull_up: 16'hFFFF,
        mask: 16'hFFFF,
        open_drain: 2'h0
    };

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_CMD = 4'b0011,
        ST_CMD_ACK = 4'b0100,
        ST_WR = 4'b0101,
        ST_WR_ACK = 4'b0110,
        ST_RD = 4'b0111,
        ST_RD_ACK = 4'b1000
    } sgx_state_t;

endpackage

// [sgx_bus_master.sv]
`timescale 1ns/1ps
module sgx_bus_master
(
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    logic spare;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Data moves four cycles after the clock falls, once the device has let go of its
    // acknowledge, and a full cycle before the clock rises so the device sees it settled.
    task automatic bit_io(input logic b, output logic s);
        tick(1);
        sda_low = ~b;
        tick(1);
        scl = 1'b1;
        tick(3);
        s = sda;
        scl = 1'b0;
        tick(3);
    endtask

    // The long first wait lets the device drop its acknowledge before the clock rises.
    task automatic start();
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b0;
        tick(4);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, spare);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                      output logic ok);
        logic k0, k1, k2, k3;
        start();
        send({a, 1'b0}, k0);
        send(p, k1);
        send(d[7:0], k2);
        send(d[15:8], k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
                      output logic ok);
        logic k0, k1, k2;
        start();
        send({a, 1'b0}, k0);
        send(p, k1);
        start();
        send({a, 1'b1}, k2);
        recv(1'b0, d[7:0]);
        recv(1'b1, d[15:8]);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import sgx_pkg::*;
    logic mclk, sys_rst, scl, sda_o, sda_oe, alert_n_o, alert_n_oe, sda_low, ok;
    logic [2:0] strap;
    logic [15:0] gpio_i, gpio_o, gpio_oe, pull_en, pull_up, rv;
    logic [31:0] drive;
    logic [6:0] dev;
    wire sda_w;
    int errors;
    int samples_checked;

    // Open-drain bus with a pull-up: high unless somebody pulls it low.
    assign sda_w = ~(sda_oe | sda_low);
    assign dev = {ADDR_PREFIX_DEF, strap};

    sgx_core dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .SCL_I(scl), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .SLAVE_ADDR_STRAP_LSB(strap[0]),
        .SLAVE_ADDR_STRAP_MID(strap[1]), .SLAVE_ADDR_STRAP_MSB(strap[2]),
        .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .GPIO_DRIVE(drive),
        .GPIO_PULL_EN(pull_en), .GPIO_PULL_UP(pull_up), .ALERT_N_O(alert_n_o),
        .ALERT_N_OE(alert_n_oe));

    sgx_bus_master master_u (.mclk(mclk), .sda(sda_w), .scl(scl), .sda_low(sda_low));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic put(input logic [7:0] p, input logic [15:0] d);
        master_u.wr(dev, p, d, ok);
        check(ok, 1'b1);
    endtask

    task automatic get(input logic [7:0] p, input logic [15:0] exp);
        master_u.rd(dev, p, rv, ok);
        check({ok, rv}, {1'b1, exp});
    endtask

    task automatic flip(input int n);
        @(posedge mclk);
        #1;
        gpio_i[n] = ~gpio_i[n];
    endtask

    task automatic alert_is(input logic exp, input logic settle);
        for (int i = 0; i < 12 && (settle || alert_n_oe !== exp); i++)
        begin
            @(posedge mclk);
            #1;
        end
        check(alert_n_oe, exp);
    endtask

    task automatic t_reset();
        check({gpio_o, gpio_oe, pull_en, pull_up}, 64'hFFFF0000FFFFFFFF);
        check(drive, 32'hFFFFFFFF);
        check({sda_o, alert_n_o, alert_n_oe}, 3'h0);
        get(PTR_DIR0, 16'hFFFF);
        get(PTR_POL0, 16'h0000);
        get(PTR_MASK0, 16'hFFFF);
        flip(3);
        alert_is(1'b0, 1'b1);
    endtask

    task automatic t_addr();
        logic [2:0] s [2] = '{3'h5, 3'h2};
        foreach (s[i])
        begin
            strap = s[i];
            repeat (4) @(posedge mclk);
            master_u.wr(dev ^ 7'h01, PTR_OUT0, 16'h0000, ok);
            check({ok, gpio_o}, {1'b0, 16'hFFFF});
            get(PTR_OUT0, 16'hFFFF);
        end
    endtask

    task automatic t_base();
        put(PTR_OUT0, 16'h3CA5);
        put(PTR_DIR0, 16'hF000);
        check({gpio_o, gpio_oe}, 32'h3CA50FFF);
        get(PTR_OUT1, 16'hA53C);
        get(PTR_DIR0, 16'hF000);
        gpio_i = 16'h1234;
        put(PTR_POL0, 16'h00FF);
        get(PTR_IN0, 16'h12CB);
    endtask

    task automatic t_extra();
        put(PTR_OCFG, 16'h0001);
        check(gpio_oe, 16'h0F5A);
        get(PTR_OCFG, 16'h0001);
        put(PTR_OCFG, 16'h0000);
        check(gpio_oe, 16'h0FFF);
        put(PTR_DRV0, 16'hE41B);
        put(PTR_DRV2, 16'h5AC3);
        check(drive, 32'h5AC3E41B);
        put(PTR_PEN0, 16'h0F0F);
        put(PTR_PSEL0, 16'h3355);
        check({pull_en, pull_up}, 32'h0F0F3355);
    endtask

    task automatic t_alert();
        put(PTR_MASK0, 16'hFFFC);
        alert_is(1'b0, 1'b1);
        flip(2);
        alert_is(1'b0, 1'b1);
        flip(0);
        alert_is(1'b1, 1'b0);
        get(PTR_SRC0, 16'h0001);
        put(PTR_SRC0, 16'hFFFF);
        get(PTR_SRC0, 16'h0001);
        check(alert_n_oe, 1'b1);
        get(PTR_IN0, 16'h12CE);
        check(alert_n_oe, 1'b0);
        get(PTR_SRC0, 16'h0000);
    endtask

    // The pin pulses and returns, so only the latch can keep the alert up.
    task automatic t_latch();
        put(PTR_LAT0, 16'h0001);
        flip(0);
        alert_is(1'b1, 1'b0);
        flip(0);
        alert_is(1'b1, 1'b1);
        get(PTR_IN0, 16'h12CF);
        get(PTR_IN0, 16'h12CE);
        check(alert_n_oe, 1'b0);
    endtask

    initial
    begin
        errors = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        strap = 3'h5;
        gpio_i = 16'h0000;
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        t_addr();
        t_base();
        t_extra();
        t_alert();
        t_latch();
        test_done();
    end

    // About thirty transfers of under five hundred cycles each fit well inside this span.
    initial
    begin
        #5000000;
        errors++;
        test_done();
    end
endmodule
